// File: hw/dsrc_clkgen.sv
`timescale 1ns/10ps
`include "dsrc_defs.svh"

module dsrc_clkgen
    import dsrc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic boot,
    input wire logic write,
    input wire logic stop_req,
    output logic cpu_clk,
    output logic cpu_clk_x2,
    output logic [1:0] phase,
    output logic tick16,
    output logic stretching
);

    logic [1:0] div_q;
    logic [3:0] pre_q;
    logic stretch_q;
    logic stretch_hold;
    logic freeze;
    logic adv;

    // ****************************************
    // free divide by sixteen
    // ****************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pre_q <= 4'h0;
        else
            pre_q <= pre_q + 4'h1;
    end

    assign tick16 = (pre_q == `DSRC_PRE_LAST);

    // extra high tick in a write, once per cycle
    assign stretch_hold = (div_q == `DSRC_DIV_LAST) && write && !stretch_q;
    // stop only in the low phase so the row strobe is never parked low
    assign freeze = stop_req && (div_q == `DSRC_DIV_RISE);
    assign adv = !stretch_hold && !freeze && (!boot || tick16);

    // ****************************************
    // divide by four
    // ****************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            div_q <= 2'h0;
        else if (adv)
            div_q <= div_q + 2'h1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            stretch_q <= 1'b0;
        else if (stretch_hold)
            stretch_q <= 1'b1;
        else if (adv)
            stretch_q <= 1'b0;
    end

    assign cpu_clk = div_q[1];
    assign cpu_clk_x2 = div_q[0];
    assign phase = div_q;
    assign stretching = stretch_q;

endmodule

// File: hw/dsrc_defs.svh
`ifndef DSRC_DEFS_SVH
`define DSRC_DEFS_SVH

// ****************************************
// master clock and processor clock
// ****************************************
`define DSRC_CLK_NS 50
`define DSRC_DIV_LAST 2'h3
`define DSRC_DIV_RISE 2'h1
`define DSRC_PRE_LAST 4'hF

// ****************************************
// refresh timer, divide by ten
// ****************************************
`define DSRC_REF_LAST 4'hA
`define DSRC_REF_ADDR_RST 8'h00

// ****************************************
// reset monostable
// ****************************************
`define DSRC_RST_PULSE_NS 100000
`define DSRC_RST_CYCLES ((`DSRC_RST_PULSE_NS + `DSRC_CLK_NS - 1) / `DSRC_CLK_NS)
`define DSRC_RST_CNT_W 11

// ****************************************
// inter-processor interface window, addr[15:3]
// ****************************************
`define DSRC_IPI_BASE 13'h1FFF

// ****************************************
// strobe watchdog used by checks
// ****************************************
`define DSRC_RAS_LOW_MAX 7'h40

`endif

// File: hw/dsrc_pkg.sv
package dsrc_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic rw;
        logic sync;
        logic phase_two;
    } dsrc_cpu_bus_t;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic [7:0] addr;
        logic addr_oe;
    } dsrc_dram_bus_t;

endpackage

// File: hw/dsrc_top.sv
`timescale 1ns/10ps
`include "dsrc_defs.svh"

// What this block does
// - refresh timer divides sixteenth-rate ticks by ten
// - each refresh advances eight-bit refresh row
// - inverted request combined with opcode fetch
// - refresh buffer enable pulses low per request
// - flip-flop restarts timer after serviced refresh
// - row strobe is inverse of processor clock
// - run-mode write cycles stretch clock high, lengthening strobe
// - row strobe never held low for long
// - column strobe suppressed for interface addresses
// - read column strobe follows phase-two clock
// - write column strobe timed by double clock
// - one flop strobes, one flop stretches clock
// - processor clock is master divided by four
// - boot mode slows divider by sixteen more
// - reset enters boot mode held by flop
// - address decoder selects interface window
// - reset pulse follows release of break key
// - flop flags simultaneous interface access collision
// - shared strobes drive eight 64Kbit chips
// - processor and refresh addresses share lines
// - collision stops the processor clock divider
// - boot clock sixty-fourth, run clock quarter
// - first interface access ends boot mode
module dsrc_top
    import dsrc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input dsrc_cpu_bus_t cpu_bus,
    input wire logic host_ipi_access,
    input wire logic break_key_n,
    output logic cpu_input_clock,
    output logic cpu_reset_n,
    output dsrc_dram_bus_t dram,
    output logic refresh_addr_oe_n,
    output logic cpu_addr_oe_n,
    output logic rom_sel_n,
    output logic ipi_sel_n,
    output logic boot_mode
);

    // ****************************************
    // decoding
    // ****************************************
    function automatic logic is_ipi(input logic [15:0] a);
        is_ipi = (a[15:3] == `DSRC_IPI_BASE);
    endfunction

    logic cpu_clk;
    logic cpu_clk_x2;
    logic [1:0] phase;
    logic tick16;
    logic stretching;
    logic boot_q;
    logic coll_q;
    logic break_prev_q;
    logic [`DSRC_RST_CNT_W-1:0] rst_cnt_q;
    logic rst_q;
    logic [3:0] ref_tmr_q;
    logic ref_req;
    logic ref_req_n_q;
    logic service;
    logic [7:0] ref_addr_q;
    logic cpu_ipi;
    logic cas_n_d;

    dsrc_clkgen u_clkgen (
        .clk(clk),
        .resetn(resetn),
        .boot(boot_q),
        .write(!cpu_bus.rw),
        .stop_req(coll_q),
        .cpu_clk(cpu_clk),
        .cpu_clk_x2(cpu_clk_x2),
        .phase(phase),
        .tick16(tick16),
        .stretching(stretching)
    );

    // address valid only in the clock high half
    assign cpu_ipi = cpu_clk && is_ipi(cpu_bus.addr);

    // ****************************************
    // reset monostable and boot flag
    // ****************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            break_prev_q <= 1'b1;
        else
            break_prev_q <= break_key_n;
    end

    // power-up loads the full pulse as well
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rst_cnt_q <= `DSRC_RST_CNT_W'(`DSRC_RST_CYCLES);
        else if (!break_key_n || (break_key_n && !break_prev_q))
            rst_cnt_q <= `DSRC_RST_CNT_W'(`DSRC_RST_CYCLES);
        else if (rst_cnt_q != '0)
            rst_cnt_q <= rst_cnt_q - `DSRC_RST_CNT_W'(1);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rst_q <= 1'b1;
        else
            rst_q <= (rst_cnt_q != '0) || !break_key_n;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            boot_q <= 1'b1;
        else if (rst_q)
            boot_q <= 1'b1;
        else if (cpu_ipi)
            boot_q <= 1'b0;
    end

    // ****************************************
    // collision flag
    // ****************************************
    // set and clear never meet in one tick: the set needs host_ipi_access high, the clear needs it low
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            coll_q <= 1'b0;
        else if (host_ipi_access && cpu_ipi)
            coll_q <= 1'b1;
        else if (!host_ipi_access)
            coll_q <= 1'b0;
    end

    // ****************************************
    // refresh timer and address
    // ****************************************
    assign ref_req = (ref_tmr_q == `DSRC_REF_LAST);
    // low half of an opcode fetch: row strobe high, memory idle
    assign service = ref_req && cpu_bus.sync && (phase == 2'h0);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ref_tmr_q <= 4'h0;
        else if (service)
            ref_tmr_q <= 4'h0;
        else if (tick16 && !ref_req)
            ref_tmr_q <= ref_tmr_q + 4'h1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ref_req_n_q <= 1'b1;
        else
            ref_req_n_q <= !ref_req;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ref_addr_q <= `DSRC_REF_ADDR_RST;
        else if (service)
            ref_addr_q <= ref_addr_q + 8'h01;
    end

    // ****************************************
    // dram strobes and address lines
    // ****************************************
    always_comb
    begin
        cas_n_d = 1'b1;
        if (cpu_clk && !is_ipi(cpu_bus.addr) && !boot_q && !service)
        begin
            if (cpu_bus.rw)
                cas_n_d = !cpu_bus.phase_two;
            else
                cas_n_d = !(cpu_clk_x2 || stretching);
        end
    end

    // one block owns the whole bus; one source on the shared lines at a time
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dram.ras_n <= 1'b1;
            dram.cas_n <= 1'b1;
            dram.addr <= 8'h00;
            dram.addr_oe <= 1'b0;
            refresh_addr_oe_n <= 1'b1;
            cpu_addr_oe_n <= 1'b1;
        end
        else
        begin
            dram.ras_n <= !cpu_clk;
            dram.cas_n <= cas_n_d;
            dram.addr_oe <= 1'b1;
            refresh_addr_oe_n <= !service;
            cpu_addr_oe_n <= service;
            if (service)
                dram.addr <= ref_addr_q;
            else if (cpu_clk)
                dram.addr <= cpu_bus.addr[7:0];
            else
                dram.addr <= cpu_bus.addr[15:8];
        end
    end

    // ****************************************
    // processor side outputs
    // ****************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_input_clock <= 1'b0;
            cpu_reset_n <= 1'b0;
            rom_sel_n <= 1'b0;
            ipi_sel_n <= 1'b1;
            boot_mode <= 1'b1;
        end
        else
        begin
            cpu_input_clock <= cpu_clk;
            cpu_reset_n <= !rst_q;
            rom_sel_n <= !boot_q;
            ipi_sel_n <= !cpu_ipi;
            boot_mode <= boot_q;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [6:0] ras_low_cnt_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ras_low_cnt_q <= 7'h00;
        else if (dram.ras_n)
            ras_low_cnt_q <= 7'h00;
        else if (ras_low_cnt_q != 7'h7F)
            ras_low_cnt_q <= ras_low_cnt_q + 7'h01;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_ras_low_bound: assert property (ras_low_cnt_q < `DSRC_RAS_LOW_MAX)
        else $error("row strobe low too long");
    a_ras_tracks_clk: assert property (cpu_input_clock == !dram.ras_n)
        else $error("row strobe not inverse of cpu clock");
    a_timer_restart: assert property (service |=> ref_tmr_q == 4'h0 && !ref_req_n_q)
        else $error("refresh timer not restarted");
    a_ref_addr_step: assert property (service |=> ref_addr_q == $past(ref_addr_q) + 8'h01)
        else $error("refresh row did not advance");
    a_ref_oe_pulse: assert property (service |=> !refresh_addr_oe_n && cpu_addr_oe_n ##1
        refresh_addr_oe_n)
        else $error("refresh buffer enable not a single pulse");
    a_ref_idle_mem: assert property (!refresh_addr_oe_n |-> dram.ras_n && dram.cas_n)
        else $error("refresh overlaps memory access");
    a_cas_ipi_block: assert property (!ipi_sel_n |-> dram.cas_n)
        else $error("column strobe during interface access");
    a_cas_read: assert property (cpu_clk && cpu_bus.rw && cpu_bus.phase_two && !boot_q
        && !is_ipi(cpu_bus.addr) && !service |=> !dram.cas_n)
        else $error("read column strobe missing");
    a_run_divide: assert property (!boot_q && !coll_q && cpu_bus.rw
        && phase != `DSRC_DIV_LAST |=> phase == $past(phase) + 2'h1)
        else $error("run clock not divide by four");
    a_boot_slow: assert property (boot_q && !tick16 |=> $stable(phase))
        else $error("boot clock not slowed");
    a_write_stretch: assert property (!boot_q && !cpu_bus.rw
        && phase == `DSRC_DIV_LAST && !stretching |=> phase == `DSRC_DIV_LAST)
        else $error("write high phase not stretched");
    a_coll_stop: assert property (coll_q && phase == `DSRC_DIV_RISE
        |=> phase == `DSRC_DIV_RISE)
        else $error("clock ran during collision");
    a_coll_flag: assert property (host_ipi_access && cpu_ipi |=> coll_q)
        else $error("collision not flagged");
    a_boot_end: assert property ($fell(boot_q) |-> $past(cpu_ipi))
        else $error("boot ended without interface access");
    a_reset_boot: assert property (rst_q |=> boot_q)
        else $error("reset did not enter boot mode");
    a_break_pulse: assert property ($rose(break_key_n) |=> rst_q [*8])
        else $error("reset pulse too short");
    a_ref_request: assert property (tick16 && ref_tmr_q == 4'h9 && !service |=> ref_req)
        else $error("refresh request not raised");

    c_refresh: cover property (service ##1 !refresh_addr_oe_n);
    c_boot_exit: cover property ($fell(boot_q));
    c_collision: cover property ($rose(coll_q));
    c_write_stretch: cover property (!boot_q && stretching);

endmodule

// File: tb/dsrc_cpu_model.sv
`timescale 1ns/10ps

// ****************************************
// processor side: follows the input clock
// ****************************************
module dsrc_cpu_model
    import dsrc_pkg::*;
(
    input wire logic clk,
    input wire logic cpu_input_clock,
    input wire logic wr,
    input wire logic ipi,
    output dsrc_cpu_bus_t bus
);
    logic clk_q;
    logic [14:0] pc_q;

    initial
    begin
        bus = '0;
        bus.rw = 1'b1;
        clk_q = 1'b0;
        pc_q = 15'h0;
    end

    // new cycle starts on the falling clock; fetch on every other cycle
    always @(negedge clk)
    begin
        clk_q <= cpu_input_clock;
        bus.phase_two <= cpu_input_clock;
        if (clk_q && !cpu_input_clock)
        begin
            pc_q <= pc_q + 15'h1;
            bus.sync <= !bus.sync;
            bus.rw <= !wr;
            bus.addr <= ipi ? 16'hFFF8 : {1'b0, pc_q};
        end
    end
endmodule

// File: tb/dsrc_top_tb.sv
`timescale 1ns/10ps

module dsrc_top_tb;
    import dsrc_pkg::*;
    logic clk = 1'b0;
    logic resetn, host_ipi_access, break_key_n, wr, ipi;
    logic cpu_input_clock, cpu_reset_n, refresh_addr_oe_n, cpu_addr_oe_n;
    logic rom_sel_n, ipi_sel_n, boot_mode;
    logic [7:0] a0;
    logic [15:0] n, c;
    int k;
    dsrc_cpu_bus_t cpu_bus;
    dsrc_dram_bus_t dram;
    int n_errors, compares;

    dsrc_cpu_model cpu_u (.clk(clk), .cpu_input_clock(cpu_input_clock), .wr(wr),
        .ipi(ipi), .bus(cpu_bus));

    dsrc_top dut_u (.clk(clk), .resetn(resetn), .cpu_bus(cpu_bus),
        .host_ipi_access(host_ipi_access), .break_key_n(break_key_n),
        .cpu_input_clock(cpu_input_clock), .cpu_reset_n(cpu_reset_n), .dram(dram),
        .refresh_addr_oe_n(refresh_addr_oe_n), .cpu_addr_oe_n(cpu_addr_oe_n),
        .rom_sel_n(rom_sel_n), .ipi_sel_n(ipi_sel_n), .boot_mode(boot_mode));

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int m);
        repeat (m) @(negedge clk);
    endtask

    // length of next high phase, and column strobe low samples within it
    task automatic high_len(output logic [15:0] len, output logic [15:0] cas);
        int j;
        j = 0;
        len = 16'h0;
        cas = 16'h0;
        while (cpu_input_clock !== 1'b0 && j < 200)
        begin
            cyc(1);
            j++;
        end
        while (cpu_input_clock !== 1'b1 && j < 400)
        begin
            cyc(1);
            j++;
        end
        while (cpu_input_clock === 1'b1 && j < 600)
        begin
            chk(dram.ras_n, 1'b0);
            if (dram.cas_n === 1'b0)
                cas++;
            cyc(1);
            len++;
            j++;
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk(boot_mode, 1'b1);
        chk(rom_sel_n, 1'b0);
        chk(dram.ras_n, 1'b1);
        chk(dram.addr_oe, 1'b0);
        resetn <= 1'b1;
        cyc(1990);
        chk(cpu_reset_n, 1'b0);
        cyc(20);
        chk(cpu_reset_n, 1'b1);
    endtask

    task automatic t_boot_exit();
        high_len(n, c);
        chk(n, 16'h20);
        ipi <= 1'b1;
        k = 0;
        while (boot_mode !== 1'b0 && k < 300)
        begin
            cyc(1);
            k++;
        end
        chk(boot_mode, 1'b0);
        chk(rom_sel_n, 1'b1);
        n = 16'h0;
        c = 16'h0;
        repeat (40)
        begin
            cyc(1);
            if (ipi_sel_n === 1'b0)
                n++;
            if (dram.cas_n === 1'b0)
                c++;
        end
        chk(n > 0, 1'b1);
        chk(c, 16'h0);
        ipi <= 1'b0;
        cyc(8);
        high_len(n, c);
        chk(n, 16'h2);
        chk(c > 0, 1'b1);
    endtask

    // stretched high phase carries the column strobe
    task automatic t_write();
        wr <= 1'b1;
        high_len(n, c);
        high_len(n, c);
        chk(n, 16'h3);
        chk(c > 0, 1'b1);
        wr <= 1'b0;
    endtask

    task automatic t_refresh();
        k = 0;
        while (refresh_addr_oe_n !== 1'b0 && k < 600)
        begin
            cyc(1);
            k++;
        end
        a0 = dram.addr;
        chk(cpu_addr_oe_n, 1'b1);
        chk(dram.addr_oe, 1'b1);
        chk(dram.ras_n, 1'b1);
        cyc(1);
        chk(refresh_addr_oe_n, 1'b1);
        k = 1;
        while (refresh_addr_oe_n !== 1'b0 && k < 600)
        begin
            cyc(1);
            k++;
        end
        // ten ticks from restart, tick skew up to 15, fetch low phase wait up to 7
        chk(k >= 146 && k <= 168, 1'b1);
        chk(dram.addr, a0 + 8'h01);
    endtask

    // both sides on the interface at once stops the clock low
    task automatic t_collision();
        host_ipi_access <= 1'b1;
        ipi <= 1'b1;
        cyc(30);
        n = 0;
        repeat (20)
        begin
            cyc(1);
            if (cpu_input_clock !== 1'b0)
                n++;
        end
        chk(n, 16'h0);
        host_ipi_access <= 1'b0;
        ipi <= 1'b0;
        high_len(n, c);
        chk(n, 16'h2);
    endtask

    task automatic t_break();
        break_key_n <= 1'b0;
        cyc(20);
        chk(cpu_reset_n, 1'b0);
        break_key_n <= 1'b1;
        cyc(2010);
        chk(cpu_reset_n, 1'b1);
        chk(boot_mode, 1'b1);
        chk(rom_sel_n, 1'b0);
    endtask

    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial
    begin
        forever #25 clk = !clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        n_errors = 0;
        compares = 0;
        resetn = 1'b0;
        host_ipi_access = 1'b0;
        break_key_n = 1'b1;
        wr = 1'b0;
        ipi = 1'b0;
        cyc(10);
        t_reset();
        t_boot_exit();
        t_write();
        t_refresh();
        t_collision();
        t_break();
        report_and_stop();
    end
endmodule
